// ---- logic/tpg_ports.sv ----
// three-port general purpose i/o block with register access
`timescale 1ns/10ps
`include "tpg_cfg.svh"

// Operation
// [R1] crystal mode gives port-2 bits 3:2 to oscillator
// [R2] external clock frees bit 2, takes bit 3
// [R3] direction registers reset to all ones
// [R4] direction 0 drives pin, 1 inputs
// [R5] read returns pin in input, latch in output
// [R6] latch 0 drives low, 1 high
// [R7] output latches clear on reset
// [R8] port-2 data bits 7:4 read zero
// [R9] port-3 data holds bits 2 and 4 only
// [R10] port-3 bit 4 read-only pin level
// [R11] port-4 data has eight latch bits
// [R12] port-2 direction bits 7:4 fixed one
// [R13] port-4 eight dirs, port-3 only bit 2
// [R14] direction registers take bit and byte writes
// [R15] port-3 bit 2 feeds interrupt input
// [R16] interrupt pins flag edges even when outputs
// [R17] shared reset pin until option selects input
// [R18] low reset pin before option read holds reset
// [R19] port-4 pull-ups follow select bits
// [R20] pull-up select 1 connects, reset clears
// [R21] input-mode writes update latch, pin undriven
// [R22] fixed bits ignore writes, read fixed value
// [R23] pull-up active only in input mode
module tpg_ports
  import tpg_pkg::*;
(
  // clock and reset
  input  wire logic            clk_sys_in,
  input  wire logic            reset_in,
  // option settings: clock source read at all times, reset pin option after reset release
  input  wire tpg_clk_src_type clk_src_in,
  input  wire logic            rst_pin_gpio_opt_in,
  // processor register access
  input  wire tpg_bus_type     bus_in,
  output logic [7:0]           rdata_out,
  // port 2 pins
  input  wire logic [3:0]      p2_pin_in,
  output logic [3:0]           p2_pin_out,
  output logic [3:0]           p2_pin_oe_out,
  output logic [3:0]           p2_pullup_out,
  // port 3 pins
  input  wire logic            p3_bidir_pin_in,
  output logic                 p3_bidir_pin_out,
  output logic                 p3_bidir_pin_oe_out,
  output logic                 p3_bidir_pullup_out,
  input  wire logic            p3_input_pin_in,
  // port 4 pins
  input  wire logic [7:0]      p4_pin_in,
  output logic [7:0]           p4_pin_out,
  output logic [7:0]           p4_pin_oe_out,
  output logic [7:0]           p4_pullup_out,
  // system side
  output logic                 sys_reset_hold_out,
  output logic                 intp0_req_out,
  output logic                 intp1_req_out
);

  tpg_state_regs_type st_r;
  tpg_state_regs_type st_nxt;
  logic [3:0] p2_io_ok;
  logic [7:0] p2_in_v;
  logic [7:0] p3_in_v;
  logic [7:0] p4_in_v;

  // pin usability of port 2 under the selected clock source
  always_comb begin
    p2_io_ok = 4'h0f;
    // [R1] crystal takes both
    if (clk_src_in == TPG_CLK_XTAL) begin
      p2_io_ok = 4'h03;
    end
    // [R2] external clock takes bit 3
    if (clk_src_in == TPG_CLK_EXT) begin
      p2_io_ok = 4'h07;
    end
  end

  // pin levels arranged as register images
  always_comb begin
    p2_in_v = {4'h0, p2_pin_in & p2_io_ok};
    p3_in_v = 8'h00;
    p3_in_v[`TPG_P3_IO_BIT] = p3_bidir_pin_in;
    // [R10] pin level, zero unless option selects input
    p3_in_v[`TPG_P3_IN_BIT] = p3_input_pin_in & st_r.rst_pin_gpio;
    p4_in_v = p4_pin_in;
  end

  // merge a bit or byte write into an old value
  function automatic logic [7:0] tpg_merge(input logic [7:0] old_v,
                                           input tpg_bus_type b);
    logic [7:0] res;
    res = old_v;
    if (b.bit_op) begin
      res[b.bit_sel] = b.wdata[0];
    end else begin
      res = b.wdata;
    end
    return res;
  endfunction

  // read image: pin in input mode, latch in output mode
  function automatic logic [7:0] tpg_view(input logic [7:0] dir,
                                          input logic [7:0] lat,
                                          input logic [7:0] pin,
                                          input logic [7:0] msk);
    return ((dir & pin) | (~dir & lat)) & msk;
  endfunction

  // next-state logic for registers, sequencing and edge flags
  always_comb begin
    logic wr_ok;
    wr_ok = 1'b0;
    st_nxt = st_r;
    st_nxt.intp0 = 1'b0;
    st_nxt.intp1 = 1'b0;
    st_nxt.rdata = 8'h00;
    // [R17] option sampled every cycle in TPG_ST_OPT after release
    unique case (st_r.state)
      TPG_ST_HOLD: begin
        st_nxt.state = TPG_ST_OPT;
      end
      TPG_ST_OPT: begin
        st_nxt.rst_pin_gpio = rst_pin_gpio_opt_in;
        // [R18] low pin keeps reset unless option selects input
        if (rst_pin_gpio_opt_in || p3_input_pin_in) begin
          st_nxt.state = TPG_ST_RUN;
        end
      end
      TPG_ST_RUN: begin
        wr_ok = bus_in.wr;
      end
    endcase
    // [R15] bidir pin feeds interrupt
    st_nxt.p32_prev = p3_bidir_pin_in;
    st_nxt.p21_prev = p2_pin_in[1];
    // [R16] edges flag in any mode
    st_nxt.intp1 = (p3_bidir_pin_in != st_r.p32_prev);
    st_nxt.intp0 = (p2_pin_in[1] != st_r.p21_prev);
    if (wr_ok) begin
      unique case (bus_in.addr)
        // [R21] latch written in any mode
        `TPG_OFS_P2_DATA: st_nxt.p2_data =
          tpg_merge(st_r.p2_data, bus_in) & `TPG_P2_MASK;
        // [R10] input bit not writable
        `TPG_OFS_P3_DATA: st_nxt.p3_data =
          tpg_merge(st_r.p3_data, bus_in) & `TPG_P3_MASK;
        // [R11] full byte latch
        `TPG_OFS_P4_DATA: st_nxt.p4_data = tpg_merge(st_r.p4_data, bus_in);
        // [R14] bit or byte writes; [R22] fixed bits stay one
        `TPG_OFS_P2_DIR: st_nxt.p2_dir =
          tpg_merge(st_r.p2_dir, bus_in) | ~`TPG_P2_MASK;
        // [R13] only bit 2 writable
        `TPG_OFS_P3_DIR: st_nxt.p3_dir =
          tpg_merge(st_r.p3_dir, bus_in) | ~`TPG_P3_MASK;
        `TPG_OFS_P4_DIR: st_nxt.p4_dir = tpg_merge(st_r.p4_dir, bus_in);
        // [R20] pull-up selects
        `TPG_OFS_P2_PU: st_nxt.p2_pu =
          tpg_merge(st_r.p2_pu, bus_in) & `TPG_P2_MASK;
        `TPG_OFS_P3_PU: st_nxt.p3_pu =
          tpg_merge(st_r.p3_pu, bus_in) & `TPG_P3_MASK;
        `TPG_OFS_P4_PU: st_nxt.p4_pu = tpg_merge(st_r.p4_pu, bus_in);
        default: ;
      endcase
    end
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        // [R5] mode-dependent read; [R8] upper bits zero
        // [R1] oscillator bits read zero in any mode
        `TPG_OFS_P2_DATA: st_nxt.rdata =
          tpg_view(st_r.p2_dir, st_r.p2_data, p2_in_v, {4'h0, p2_io_ok});
        // [R9] bits 2 and 4 only
        `TPG_OFS_P3_DATA: st_nxt.rdata =
          tpg_view(st_r.p3_dir, st_r.p3_data, p3_in_v, `TPG_P3_MASK)
          | (p3_in_v & 8'h10);
        `TPG_OFS_P4_DATA: st_nxt.rdata =
          tpg_view(st_r.p4_dir, st_r.p4_data, p4_in_v, 8'hff);
        `TPG_OFS_P2_DIR:  st_nxt.rdata = st_r.p2_dir;
        `TPG_OFS_P3_DIR:  st_nxt.rdata = st_r.p3_dir;
        `TPG_OFS_P4_DIR:  st_nxt.rdata = st_r.p4_dir;
        `TPG_OFS_P2_PU:   st_nxt.rdata = st_r.p2_pu;
        `TPG_OFS_P3_PU:   st_nxt.rdata = st_r.p3_pu;
        `TPG_OFS_P4_PU:   st_nxt.rdata = st_r.p4_pu;
        default:          st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st_r.state        <= TPG_ST_HOLD;
      // [R7] latches clear
      st_r.p2_data      <= `TPG_RST_DATA;
      st_r.p3_data      <= `TPG_RST_DATA;
      st_r.p4_data      <= `TPG_RST_DATA;
      // [R3] all inputs
      st_r.p2_dir       <= `TPG_RST_DIR;
      st_r.p3_dir       <= `TPG_RST_DIR;
      st_r.p4_dir       <= `TPG_RST_DIR;
      // [R20] pull-ups off
      st_r.p2_pu        <= `TPG_RST_PU;
      st_r.p3_pu        <= `TPG_RST_PU;
      st_r.p4_pu        <= `TPG_RST_PU;
      st_r.rdata        <= 8'h00;
      st_r.rst_pin_gpio <= 1'b0;
      st_r.p32_prev     <= 1'b0;
      st_r.intp1        <= 1'b0;
      st_r.p21_prev     <= 1'b0;
      st_r.intp0        <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // pin drivers for port 2 and port 4, one bit each
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_p4
      // [R4] dir 0 enables; [R6] latch level
      assign p4_pin_out[gi]    = st_r.p4_data[gi];
      assign p4_pin_oe_out[gi] = ~st_r.p4_dir[gi];
      // [R19] select per bit; [R23] input mode only
      assign p4_pullup_out[gi] = st_r.p4_pu[gi] & st_r.p4_dir[gi];
    end
    for (gi = 0; gi < 4; gi++) begin : g_p2
      assign p2_pin_out[gi]    = st_r.p2_data[gi];
      // [R1] oscillator pins never driven
      assign p2_pin_oe_out[gi] = ~st_r.p2_dir[gi] & p2_io_ok[gi];
      assign p2_pullup_out[gi] = st_r.p2_pu[gi] & st_r.p2_dir[gi]
                                 & p2_io_ok[gi];
    end
  endgenerate

  // port 3 driver and system outputs
  assign p3_bidir_pin_out    = st_r.p3_data[`TPG_P3_IO_BIT];
  assign p3_bidir_pin_oe_out = ~st_r.p3_dir[`TPG_P3_IO_BIT];
  assign p3_bidir_pullup_out = st_r.p3_pu[`TPG_P3_IO_BIT]
                               & st_r.p3_dir[`TPG_P3_IO_BIT];
  assign rdata_out           = st_r.rdata;
  assign sys_reset_hold_out  = (st_r.state != TPG_ST_RUN);
  assign intp0_req_out       = st_r.intp0;
  assign intp1_req_out       = st_r.intp1;

endmodule

// ---- inc/tpg_cfg.svh ----
// register offsets, field positions and reset values of the port block
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH
`define TPG_OFS_P2_DATA   16'hff02
`define TPG_OFS_P3_DATA   16'hff03
`define TPG_OFS_P4_DATA   16'hff04
`define TPG_OFS_P2_DIR    16'hff22
`define TPG_OFS_P3_DIR    16'hff23
`define TPG_OFS_P4_DIR    16'hff24
`define TPG_OFS_P2_PU     16'hff32
`define TPG_OFS_P3_PU     16'hff33
`define TPG_OFS_P4_PU     16'hff34
`define TPG_RST_DATA      8'h00
`define TPG_RST_DIR       8'hff
`define TPG_RST_PU        8'h00
`define TPG_P2_MASK       8'h0f
`define TPG_P3_MASK       8'h04
`define TPG_P3_IN_BIT     4
`define TPG_P3_IO_BIT     2
`define TPG_RDY_CYCLES    4'h2
`endif

// ---- inc/tpg_pkg.sv ----
// types shared by the port block
package tpg_pkg;
  typedef enum logic [1:0] {
    TPG_CLK_INT,
    TPG_CLK_XTAL,
    TPG_CLK_EXT
  } tpg_clk_src_type;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        bit_op;
    logic [2:0]  bit_sel;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } tpg_bus_type;

  typedef enum logic [1:0] {
    TPG_ST_HOLD,
    TPG_ST_OPT,
    TPG_ST_RUN
  } tpg_state_type;

  typedef struct packed {
    tpg_state_type state;
    logic [7:0]    p2_data;
    logic [7:0]    p3_data;
    logic [7:0]    p4_data;
    logic [7:0]    p2_dir;
    logic [7:0]    p3_dir;
    logic [7:0]    p4_dir;
    logic [7:0]    p2_pu;
    logic [7:0]    p3_pu;
    logic [7:0]    p4_pu;
    logic [7:0]    rdata;
    logic          rst_pin_gpio;
    logic          p32_prev;
    logic          intp1;
    logic          p21_prev;
    logic          intp0;
  } tpg_state_regs_type;
endpackage

// ---- dv/tpg_ports_sva.sv ----
// concurrent checks on the port block boundary
`timescale 1ns/10ps
`include "tpg_cfg.svh"
module tpg_ports_sva
  import tpg_pkg::*;
(
  // clock, reset and controls
  input wire logic            clk_sys_in,
  input wire logic            reset_in,
  input wire tpg_clk_src_type clk_src_in,
  input wire logic            rst_pin_gpio_opt_in,
  input wire tpg_bus_type     bus_in,
  // pins and system outputs
  input wire logic [3:0]      p2_pin_oe_out,
  input wire logic [3:0]      p2_pullup_out,
  input wire logic            p3_bidir_pin_in,
  input wire logic            p3_input_pin_in,
  input wire logic [7:0]      p4_pin_out,
  input wire logic [7:0]      p4_pin_oe_out,
  input wire logic [7:0]      p4_pullup_out,
  input wire logic            sys_reset_hold_out,
  input wire logic            intp1_req_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // byte write taken in run state
  sequence s_wr(logic [15:0] a);
    bus_in.wr && !bus_in.bit_op && bus_in.addr == a && !sys_reset_hold_out;
  endsequence
  AST_RST_STATE: assert property (
    $fell(reset_in) |-> p4_pin_oe_out == 8'h00 && p4_pin_out == 8'h00)
    else $error("port state wrong after reset");
  AST_P4_DIR: assert property (
    s_wr(`TPG_OFS_P4_DIR) |=> p4_pin_oe_out == ~$past(bus_in.wdata))
    else $error("port four buffer enables do not follow direction");
  AST_P4_DATA: assert property (
    s_wr(`TPG_OFS_P4_DATA) |=> p4_pin_out == $past(bus_in.wdata))
    else $error("port four pins do not follow latch");
  AST_XTAL: assert property (
    clk_src_in == TPG_CLK_XTAL |-> (p2_pin_oe_out | p2_pullup_out) < 4'h4)
    else $error("oscillator pins used as port");
  AST_EXT: assert property (
    clk_src_in == TPG_CLK_EXT |-> !p2_pin_oe_out[3] && !p2_pullup_out[3])
    else $error("clock input pin used as port");
  AST_PU_GATE: assert property (
    (p4_pullup_out & p4_pin_oe_out) == 8'h00)
    else $error("pull-up on while driving");
  AST_HOLD: assert property (
    sys_reset_hold_out && !p3_input_pin_in && !rst_pin_gpio_opt_in
    |=> sys_reset_hold_out)
    else $error("reset released with reset pin low");
  AST_LOCK: assert property (
    sys_reset_hold_out && bus_in.wr |=> $stable(p4_pin_oe_out))
    else $error("write taken while held");
  AST_INTP1: assert property (
    !$past(reset_in) && $changed(p3_bidir_pin_in) |=> intp1_req_out)
    else $error("no request on pin change");
endmodule

// ---- dv/tpg_pin_model.sv ----
// external parties wired to one port's pins
`timescale 1ns/10ps
module tpg_pin_model #(
  parameter int W = 8
) (
  // clock and device side
  input  wire logic         clk_sys_in,
  input  wire logic [W-1:0] out_in,
  input  wire logic [W-1:0] oe_in,
  input  wire logic [W-1:0] pu_in,
  // external driver and resolved level
  input  wire logic [W-1:0] ext_in,
  input  wire logic [W-1:0] ext_en_in,
  output logic [W-1:0]      pin_out
);
  logic [W-1:0] float_r = '0;
  // an open line wanders every cycle
  always_ff @(posedge clk_sys_in) begin
    float_r <= ~float_r;
  end
  assign pin_out = (oe_in & out_in) | (~oe_in & ext_en_in & ext_in)
                 | (~oe_in & ~ext_en_in & (pu_in | float_r));
endmodule

// ---- dv/three_port_gpio_block_tb.sv ----
// self-checking bench for the three-port gpio block
`timescale 1ns/10ps
module three_port_gpio_block_tb
  import tpg_pkg::*;
;
  logic            clk_sys_in = 1'b0;
  logic            reset_in   = 1'b1;
  tpg_clk_src_type clk_src    = TPG_CLK_INT;
  logic            opt        = 1'b0;
  logic            rst_pin    = 1'b0;
  tpg_bus_type     bus        = '0;
  logic [7:0]      rdata;
  logic [3:0]      p2_out, p2_oe, p2_pu, p2_pin;
  logic            p3_out, p3_oe, p3_pu, p3_pin, hold, intp1, intp0;
  logic [3:0]      p2_ext = 4'h0;
  logic [3:0]      p2_en  = 4'hf;
  logic            p3_ext = 1'b0;
  logic            p3_en  = 1'b1;
  logic [7:0]      p4_ext = 8'h81;
  logic [7:0]      p4_en  = 8'hff;
  logic [7:0]      p4_out, p4_oe, p4_pu, p4_pin;
  int              n_errors   = 0;
  int              checked    = 0;
  // clock at 8 ns
  always #4 clk_sys_in = ~clk_sys_in;
  tpg_ports dut (.clk_sys_in, .reset_in, .clk_src_in(clk_src),
    .rst_pin_gpio_opt_in(opt), .bus_in(bus), .rdata_out(rdata),
    .p2_pin_in(p2_pin), .p2_pin_out(p2_out), .p2_pin_oe_out(p2_oe),
    .p2_pullup_out(p2_pu), .p3_bidir_pin_in(p3_pin),
    .p3_bidir_pin_out(p3_out), .p3_bidir_pin_oe_out(p3_oe),
    .p3_bidir_pullup_out(p3_pu), .p3_input_pin_in(rst_pin),
    .p4_pin_in(p4_pin), .p4_pin_out(p4_out), .p4_pin_oe_out(p4_oe),
    .p4_pullup_out(p4_pu), .sys_reset_hold_out(hold),
    .intp0_req_out(intp0), .intp1_req_out(intp1));
  tpg_pin_model #(.W(4)) u_p2 (.clk_sys_in, .out_in(p2_out), .oe_in(p2_oe),
    .pu_in(p2_pu), .ext_in(p2_ext), .ext_en_in(p2_en), .pin_out(p2_pin));
  tpg_pin_model #(.W(1)) u_p3 (.clk_sys_in, .out_in(p3_out), .oe_in(p3_oe),
    .pu_in(p3_pu), .ext_in(p3_ext), .ext_en_in(p3_en), .pin_out(p3_pin));
  tpg_pin_model #(.W(8)) u_p4 (.clk_sys_in, .out_in(p4_out), .oe_in(p4_oe),
    .pu_in(p4_pu), .ext_in(p4_ext), .ext_en_in(p4_en), .pin_out(p4_pin));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic b = 1'b0, input logic [2:0] s = 3'h0);
    @(posedge clk_sys_in);
    bus <= '{rd: 1'b0, wr: 1'b1, bit_op: b, bit_sel: s, addr: a, wdata: d};
    @(posedge clk_sys_in);
    bus.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk_sys_in);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic complete_run();
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // refused write, then reset values while still held
  task automatic t_regs();
    logic [15:0] ra [9] = '{16'hff02, 16'hff03, 16'hff04, 16'hff22,
      16'hff23, 16'hff24, 16'hff32, 16'hff34, 16'hff10};
    logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h81, 8'hff, 8'hff, 8'hff,
      8'h00, 8'h00, 8'h00};
    wr(16'hff24, 8'h00);
    for (int i = 0; i < 9; i++) begin
      rd(ra[i], rv[i]);
    end
    chk({7'h0, hold}, 8'h01);
  endtask
  // shared reset pin goes high, device runs
  task automatic t_release();
    int n = 0;
    @(posedge clk_sys_in);
    rst_pin <= 1'b1;
    while (hold !== 1'b0 && n < 20) begin
      @(posedge clk_sys_in);
      n++;
    end
    #1;
    chk({7'h0, hold}, 8'h00);
    if (n >= 20)
      complete_run();
  endtask
  // port four output, bit write, input latch, pull-ups
  task automatic t_port4();
    wr(16'hff24, 8'h00);
    wr(16'hff04, 8'ha5);
    chk(p4_pin, 8'ha5);
    rd(16'hff04, 8'ha5);
    wr(16'hff24, 8'h01, 1'b1, 3'h3);
    rd(16'hff24, 8'h08);
    chk(p4_oe, 8'hf7);
    wr(16'hff24, 8'hff);
    wr(16'hff04, 8'h3c);
    chk(p4_oe, 8'h00);
    rd(16'hff04, 8'h81);
    wr(16'hff34, 8'hf0);
    chk(p4_pu, 8'hf0);
    wr(16'hff24, 8'h3f);
    chk(p4_pin, 8'h01);
    chk(p4_pu, 8'h30);
  endtask
  // port two fixed bits across clock sources
  task automatic t_port2();
    tpg_clk_src_type m [3] = '{TPG_CLK_INT, TPG_CLK_XTAL, TPG_CLK_EXT};
    logic [3:0] e [3] = '{4'hf, 4'h3, 4'h7};
    wr(16'hff22, 8'h00);
    rd(16'hff22, 8'hf0);
    wr(16'hff02, 8'hff);
    @(posedge clk_sys_in);
    #1;
    chk({7'h0, intp0}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys_in);
      clk_src <= m[i];
      rd(16'hff02, {4'h0, e[i]});
      chk({4'h0, p2_oe}, {4'h0, e[i]});
    end
  endtask
  // port three bits and interrupt in output mode
  task automatic t_port3();
    wr(16'hff23, 8'h00);
    rd(16'hff23, 8'hfb);
    wr(16'hff03, 8'hff);
    rd(16'hff03, 8'h04);
    wr(16'hff03, 8'h00);
    @(posedge clk_sys_in);
    #1;
    chk({7'h0, intp1}, 8'h01);
    chk({6'h0, p3_oe, p3_out}, 8'h02);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    t_regs();
    t_release();
    t_port4();
    t_port2();
    t_port3();
    complete_run();
  end
endmodule
bind tpg_ports tpg_ports_sva u_sva (.clk_sys_in, .reset_in, .clk_src_in,
  .rst_pin_gpio_opt_in, .bus_in, .p2_pin_oe_out, .p2_pullup_out,
  .p3_bidir_pin_in, .p3_input_pin_in, .p4_pin_out, .p4_pin_oe_out,
  .p4_pullup_out, .sys_reset_hold_out, .intp1_req_out);
